// ===== pkg/dcm_pkg.sv
/*
 * Shared constants, types and arithmetic helpers for the channel modulator.
 * Assumes a single update-rate clock and 32-bit AHB-Lite register access.
 */
package dcm_pkg;

    // ****************************************
    // datapath widths
    // ****************************************
    localparam int SAMPLE_W   = 14;
    localparam int COEF_W     = 16;
    localparam int COEF_FRAC  = 14;
    localparam int FIFO_DEPTH = 16;
    localparam int PHASE_W    = 3;

    // ****************************************
    // mixing coefficients, Q2.14
    // ****************************************
    localparam logic signed [COEF_W-1:0] COEF_POS_ONE  = 16'h4000;
    localparam logic signed [COEF_W-1:0] COEF_POS_HALF = 16'h2D41;
    localparam logic signed [COEF_W-1:0] COEF_ZERO     = 16'h0000;
    localparam logic signed [COEF_W-1:0] COEF_NEG_HALF = 16'hD2BF;
    localparam logic signed [COEF_W-1:0] COEF_NEG_ONE  = 16'hC000;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;

    localparam int CTRL_W        = 8;
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_DUAL_BIT = 1;
    localparam int CTRL_CHAN_BIT = 2;
    localparam int CTRL_PART_BIT = 3;
    localparam int CTRL_MIX_LSB  = 4;
    localparam int CTRL_UPS_LSB  = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    localparam int STAT_UNDER_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_FULL_BIT  = 2;
    localparam int STAT_LVL_LSB   = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // ****************************************
    // mode encodings
    // ****************************************
    typedef enum logic [1:0] {
        MIX_NONE = 2'b00,
        MIX_DIV2 = 2'b01,
        MIX_DIV4 = 2'b10,
        MIX_DIV8 = 2'b11
    } dcm_rate_t;

    typedef enum logic [1:0] {
        UPS_X1 = 2'b00,
        UPS_X2 = 2'b01,
        UPS_X4 = 2'b10,
        UPS_X8 = 2'b11
    } dcm_ups_t;

    // ****************************************
    // helpers
    // ****************************************
    // cosine of 2*pi*idx/8
    function automatic logic signed [COEF_W-1:0] cos8(input logic [2:0] idx);
        case (idx)
            3'd0:    cos8 = COEF_POS_ONE;
            3'd1:    cos8 = COEF_POS_HALF;
            3'd2:    cos8 = COEF_ZERO;
            3'd3:    cos8 = COEF_NEG_HALF;
            3'd4:    cos8 = COEF_NEG_ONE;
            3'd5:    cos8 = COEF_NEG_HALF;
            3'd6:    cos8 = COEF_ZERO;
            default: cos8 = COEF_POS_HALF;
        endcase
    endfunction : cos8

    // phase step scaled onto the eighth-turn grid
    function automatic logic [2:0] mixIndex(input dcm_rate_t rate, input logic [2:0] ph);
        case (rate)
            MIX_DIV2: mixIndex = {ph[0], 2'b00};
            MIX_DIV4: mixIndex = {ph[1:0], 1'b0};
            MIX_DIV8: mixIndex = ph;
            default:  mixIndex = 3'd0;
        endcase
    endfunction : mixIndex

    // drop fraction and clamp to sample range
    function automatic logic signed [SAMPLE_W-1:0] satSample(input logic signed [30:0] v);
        logic signed [16:0] s;
        s = 17'(v >>> COEF_FRAC);
        if (s > 17'sd8191) begin
            satSample = 14'h1FFF;
        end else if (s < -17'sd8192) begin
            satSample = 14'h2000;
        end else begin
            satSample = s[SAMPLE_W-1:0];
        end
    endfunction : satSample

endpackage : dcm_pkg

// ===== src/dcm_sample_fifo.sv
/*
 * Synchronous FIFO for paired I/Q samples, width and depth as parameters.
 * Assumes one clock; ready on the fill side is registered.
 */
module dcm_sample_fifo
    import dcm_pkg::*;
#(
    parameter int WIDTH = 2 * SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    // fill side
    input  wire logic                     inValid,
    input  wire logic [WIDTH-1:0]         inData,
    output logic                          inReady,
    // drain side
    output logic                          outValid,
    output logic [WIDTH-1:0]              outData,
    input  wire logic                     outReady,
    // level
    output logic [$clog2(DEPTH+1)-1:0]    level
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             ready_r;
    logic             push;
    logic             pop;

    assign push     = inValid && ready_r;
    assign pop      = outReady && (count_r != '0);
    assign outValid = (count_r != '0);
    assign outData  = mem[rdPtr_r];
    assign inReady  = ready_r;
    assign level    = count_r;

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + CNT_W'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == PTR_W'(DEPTH-1)) ? '0 : wrPtr_r + PTR_W'(1);
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == PTR_W'(DEPTH-1)) ? '0 : rdPtr_r + PTR_W'(1);
            end
            count_r <= count_nxt;
            ready_r <= (count_nxt != CNT_W'(DEPTH));
        end
    end

endmodule : dcm_sample_fifo

// ===== src/dcm_interp_filter.sv
/*
 * Interpolation stage for one channel: hold at the input rate, then a
 * two-tap averaging filter at the update rate. Real, linear-phase response.
 * Assumes load pulses at the chosen input rate.
 */
module dcm_interp_filter
    import dcm_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    // input sample
    input  wire logic                     load,
    input  wire logic signed [WIDTH-1:0]  sampleIn,
    // filtered output
    output logic signed [WIDTH-1:0]       filtOut
);

    logic signed [WIDTH-1:0] hold_r;
    logic signed [WIDTH-1:0] prev_r;
    logic signed [WIDTH-1:0] out_r;
    logic signed [WIDTH:0]   sum;

    assign sum     = {hold_r[WIDTH-1], hold_r} + {prev_r[WIDTH-1], prev_r};
    assign filtOut = out_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_r <= '0;
            prev_r <= '0;
            out_r  <= '0;
        end else begin
            if (load) begin
                hold_r <= sampleIn;
            end
            prev_r <= hold_r;
            out_r  <= sum[WIDTH:1];
        end
    end

endmodule : dcm_interp_filter

// ===== src/dcm_dac_channel_modulator.sv
/*
 * Channel modulator behind the interpolation filters of a converter:
 * AHB-Lite control, input FIFO, pacing, two identical filters, real or
 * complex mixing at update rate /2, /4 or /8, output word per cycle.
 * Assumes ref_clk is the converter update clock and one AHB-Lite master.
 */
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
// How it works
// - I and Q pass through two instances of one identical real filter.
// - Single mode sends one chosen channel onward, the other is dropped.
// - Channel select 0 picks in-phase, 1 picks quadrature.
// - Rate field 00 none, 01 /2, 10 /4, 11 /8 in single mode.
// - Single mode multiplies the sample by a real cosine.
// - Dual mode multiplies I+jQ by a complex exponential.
// - Part select 0 outputs real product, 1 outputs imaginary product.
// - Dual mode uses the same rate field codes.
// - Complex mixer uses positive frequency only, pure translation.
// - Upsample field 00 x1, 01 x2, 10 x4, 11 x8 input pacing.
module dcm_dac_channel_modulator
    import dcm_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // sample input stream
    input  wire logic                 sampleValid,
    input  wire logic [SAMPLE_W-1:0]  sampleI,
    input  wire logic [SAMPLE_W-1:0]  sampleQ,
    output logic                      sampleReady,
    // converter output
    output logic [SAMPLE_W-1:0]       dacData
);

    localparam int LVL_W = $clog2(FIFO_DEPTH+1);

    // ****************************************
    // bus slave
    // ****************************************
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0]       hrdata_r;
    logic              hreadyout_r;
    logic              wrPend_r;
    logic [11:0]       wrAddr_r;
    logic              addrValid;
    logic              underrun_r;
    logic [LVL_W-1:0]  fifoLevel;
    logic              fifoReady;
    logic [31:0]       statusWord;

    assign addrValid  = hsel && htrans[1] && hready;
    assign hrdata     = hrdata_r;
    assign hreadyout  = hreadyout_r;
    assign hresp      = 1'b0;
    assign statusWord = {{(32-STAT_LVL_LSB-LVL_W){1'b0}}, fifoLevel,
                         {(STAT_LVL_LSB-STAT_FULL_BIT-1){1'b0}}, !fifoReady,
                         (fifoLevel == '0), underrun_r};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout_r <= 1'b0;
            wrPend_r    <= 1'b0;
            wrAddr_r    <= 12'h000;
        end else begin
            hreadyout_r <= 1'b1;
            wrPend_r    <= addrValid && hwrite;
            wrAddr_r    <= haddr[11:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addrValid && !hwrite) begin
            if (haddr[11:0] == REG_CTRL) begin
                hrdata_r <= {{(32-CTRL_W){1'b0}}, ctrl_r};
            end else if (haddr[11:0] == REG_STATUS) begin
                hrdata_r <= statusWord;
            end else begin
                hrdata_r <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (wrPend_r && wrAddr_r == REG_CTRL) begin
            ctrl_r <= hwdata[CTRL_W-1:0];
        end
    end

    logic      enable;
    logic      dualPath;
    logic      chanSel;
    logic      partSel;
    dcm_rate_t mixRate;
    dcm_ups_t  upsRate;

    assign enable   = ctrl_r[CTRL_EN_BIT];
    assign dualPath = ctrl_r[CTRL_DUAL_BIT];
    assign chanSel  = ctrl_r[CTRL_CHAN_BIT];
    assign partSel  = ctrl_r[CTRL_PART_BIT];
    assign mixRate  = dcm_rate_t'(ctrl_r[CTRL_MIX_LSB +: 2]);
    assign upsRate  = dcm_ups_t'(ctrl_r[CTRL_UPS_LSB +: 2]);

    // ****************************************
    // input fifo and pacing
    // ****************************************
    logic                    fifoValid;
    logic [2*SAMPLE_W-1:0]   fifoData;
    logic [2:0]              paceCnt_r;
    logic [2:0]              paceMax;
    logic                    popReq;
    logic                    load;

    dcm_sample_fifo #(
        .WIDTH (2 * SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .inValid  (sampleValid),
        .inData   ({sampleQ, sampleI}),
        .inReady  (fifoReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (popReq),
        .level    (fifoLevel)
    );

    assign sampleReady = fifoReady;

    assign paceMax = 3'((4'd1 << upsRate) - 4'd1);
    assign popReq  = enable && (paceCnt_r == 3'd0);
    assign load    = popReq && fifoValid;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            paceCnt_r <= 3'd0;
        end else if (!enable || paceCnt_r == 3'd0) begin
            paceCnt_r <= enable ? paceMax : 3'd0;
        end else begin
            paceCnt_r <= paceCnt_r - 3'd1;
        end
    end

    // sticky underrun, set wins over write-one clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            underrun_r <= 1'b0;
        end else if (popReq && !fifoValid) begin
            underrun_r <= 1'b1;
        end else if (wrPend_r && wrAddr_r == REG_STATUS && hwdata[STAT_UNDER_BIT]) begin
            underrun_r <= 1'b0;
        end
    end

    // ****************************************
    // interpolation filters
    // ****************************************
    logic signed [SAMPLE_W-1:0] filtI;
    logic signed [SAMPLE_W-1:0] filtQ;

    dcm_interp_filter #(
        .WIDTH (SAMPLE_W)
    ) u_filt_i (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .load     (load),
        .sampleIn (fifoData[SAMPLE_W-1:0]),
        .filtOut  (filtI)
    );

    dcm_interp_filter #(
        .WIDTH (SAMPLE_W)
    ) u_filt_q (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .load     (load),
        .sampleIn (fifoData[2*SAMPLE_W-1:SAMPLE_W]),
        .filtOut  (filtQ)
    );

    // ****************************************
    // mixer
    // ****************************************
    logic [PHASE_W-1:0]         phase_r;
    logic [PHASE_W-1:0]         phaseMask;
    logic [2:0]                 idx8;
    logic signed [COEF_W-1:0]   cosV;
    logic signed [COEF_W-1:0]   sinV;
    logic signed [29:0]         pIc;
    logic signed [29:0]         pQs;
    logic signed [29:0]         pIs;
    logic signed [29:0]         pQc;
    logic signed [30:0]         realSum;
    logic signed [30:0]         imagSum;
    logic signed [30:0]         mixSel;
    logic [SAMPLE_W-1:0]        dacData_r;

    assign phaseMask = (mixRate == MIX_DIV2) ? 3'b001 :
                       (mixRate == MIX_DIV4) ? 3'b011 :
                       (mixRate == MIX_DIV8) ? 3'b111 : 3'b000;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= 3'd0;
        end else begin
            phase_r <= (phase_r + 3'd1) & phaseMask;
        end
    end

    assign idx8 = mixIndex(mixRate, phase_r);
    assign cosV = cos8(idx8);
    assign sinV = cos8(idx8 - 3'd2);

    assign pIc     = filtI * cosV;
    assign pQs     = filtQ * sinV;
    assign pIs     = filtI * sinV;
    assign pQc     = filtQ * cosV;
    // complex product real and imaginary parts
    assign realSum = 31'(pIc) - 31'(pQs);
    assign imagSum = 31'(pIs) + 31'(pQc);

    always_comb begin
        mixSel = 31'sd0;
        if (dualPath) begin
            mixSel = partSel ? imagSum : realSum;
        end else begin
            mixSel = chanSel ? 31'(pQc) : 31'(pIc);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dacData_r <= '0;
        end else begin
            dacData_r <= satSample(mixSel);
        end
    end

    assign dacData = dacData_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic signed [SAMPLE_W-1:0] negI;
    logic signed [SAMPLE_W-1:0] negQ;
    assign negI = (filtI == 14'sh2000) ? 14'sh1FFF : -filtI;
    assign negQ = (filtQ == 14'sh2000) ? 14'sh1FFF : -filtQ;

    property p_single_i;
        !dualPath && !chanSel && mixRate == MIX_NONE |=> dacData_r == $past(filtI);
    endproperty
    a_single_i: assert property (p_single_i) else $error("single I bypass wrong");

    property p_single_q;
        !dualPath && chanSel && mixRate == MIX_NONE |=> dacData_r == $past(filtQ);
    endproperty
    a_single_q: assert property (p_single_q) else $error("single Q bypass wrong");

    property p_div2_toggle;
        mixRate == MIX_DIV2 && $past(mixRate) == MIX_DIV2 |-> phase_r[0] != $past(phase_r[0]);
    endproperty
    a_div2_toggle: assert property (p_div2_toggle) else $error("div2 phase stuck");

    property p_div8_wrap;
        mixRate == MIX_DIV8 [*8] |=> phase_r == $past(phase_r, 8);
    endproperty
    a_div8_wrap: assert property (p_div8_wrap) else $error("div8 period wrong");

    property p_div2_neg;
        !dualPath && !chanSel && mixRate == MIX_DIV2 && phase_r == 3'd1
            |=> dacData_r == $past(negI);
    endproperty
    a_div2_neg: assert property (p_div2_neg) else $error("div2 negation wrong");

    property p_div4_null;
        !dualPath && mixRate == MIX_DIV4 && phase_r[0] |=> dacData_r == '0;
    endproperty
    a_div4_null: assert property (p_div4_null) else $error("div4 cos null wrong");

    property p_dual_real;
        dualPath && !partSel && mixRate == MIX_NONE |=> dacData_r == $past(filtI);
    endproperty
    a_dual_real: assert property (p_dual_real) else $error("dual real wrong");

    property p_dual_imag;
        dualPath && partSel && mixRate == MIX_NONE |=> dacData_r == $past(filtQ);
    endproperty
    a_dual_imag: assert property (p_dual_imag) else $error("dual imag wrong");

    property p_dual_rot;
        dualPath && !partSel && mixRate == MIX_DIV4 && phase_r == 3'd1
            |=> dacData_r == $past(negQ);
    endproperty
    a_dual_rot: assert property (p_dual_rot) else $error("complex rotation wrong");

    property p_dual_rot_im;
        dualPath && partSel && mixRate == MIX_DIV4 && phase_r == 3'd1
            |=> dacData_r == $past(filtI);
    endproperty
    a_dual_rot_im: assert property (p_dual_rot_im) else $error("complex imag wrong");

    property p_pace_x8;
        popReq && upsRate == UPS_X8 ##1 enable [*8]
            |-> popReq && $past(paceCnt_r) == 3'd1 && $past(paceCnt_r, 7) == 3'd7;
    endproperty
    a_pace_x8: assert property (p_pace_x8) else $error("x8 pacing wrong");

    property p_filt_same;
        load && fifoData[SAMPLE_W-1:0] == fifoData[2*SAMPLE_W-1:SAMPLE_W]
            ##1 !load |-> ##2 filtI == filtQ;
    endproperty
    a_filt_same: assert property (p_filt_same) else $error("filters differ");

    c_single_div8: cover property (!dualPath && mixRate == MIX_DIV8 && load);
    c_dual_div2:   cover property (dualPath && partSel && mixRate == MIX_DIV2 && load);
    c_underrun:    cover property (popReq && !fifoValid);
    c_fifo_full:   cover property (!fifoReady && enable);

endmodule : dcm_dac_channel_modulator

// ===== bench/dcm_sample_source.sv
/*
 * Upstream sample source for the channel modulator bench.
 * Assumes the bench sets run, slow and the I/Q values off the clock edge.
 */
module dcm_sample_source
    import dcm_pkg::*;
(
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // control from the bench
    input  wire logic                run,
    input  wire logic                slow,
    input  wire logic [SAMPLE_W-1:0] valI,
    input  wire logic [SAMPLE_W-1:0] valQ,
    // stream to the modulator
    output logic                     sampleValid,
    output logic [SAMPLE_W-1:0]      sampleI,
    output logic [SAMPLE_W-1:0]      sampleQ,
    input  wire logic                sampleReady
);
    timeunit 1ns;
    timeprecision 1ps;

    logic gap_r;

    // ****************************************
    // hold a word until taken, scramble idle lines
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleValid <= 1'b0;
            sampleI     <= '0;
            sampleQ     <= '0;
            gap_r       <= 1'b0;
        end else if (!sampleValid || sampleReady) begin
            gap_r       <= slow && !gap_r;
            sampleValid <= run && !gap_r;
            sampleI     <= (run && !gap_r) ? valI : ~sampleI;
            sampleQ     <= (run && !gap_r) ? valQ : ~sampleQ;
        end
    end
endmodule : dcm_sample_source

// ===== bench/dcm_dac_channel_modulator_test.sv
/*
 * Self-checking bench: registers, FIFO fill and pacing, mixer modes.
 * Assumes one AHB-Lite master (this bench) and the sample source model.
 */
module dcm_dac_channel_modulator_test
    import dcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int COS_T [8] = '{16384, 11585, 0, -11585, -16384, -11585, 0, 11585};

    logic                ref_clk, reset_n, hsel, hwrite, hresp, hreadyout, run, slow;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    logic [1:0]          htrans;
    logic                sampleValid, sampleReady, found, ok;
    logic [SAMPLE_W-1:0] sampleI, sampleQ, valI, valQ, dacData;
    logic [SAMPLE_W-1:0] seen [16];
    logic [15:0]         lfsr;
    logic [7:0]          ctrl;
    int                  errorCnt, nCompared, cycCnt, lvl, per;

    dcm_dac_channel_modulator dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sampleValid(sampleValid), .sampleI(sampleI), .sampleQ(sampleQ),
        .sampleReady(sampleReady), .dacData(dacData));

    dcm_sample_source src_u (.ref_clk(ref_clk), .reset_n(reset_n), .run(run), .slow(slow),
        .valI(valI), .valQ(valQ), .sampleValid(sampleValid), .sampleI(sampleI),
        .sampleQ(sampleQ), .sampleReady(sampleReady));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    function automatic logic [SAMPLE_W-1:0] expDac(input int i, input int q,
                                                   input logic [7:0] c, input int idx);
        int cv;
        int sv;
        int v;
        cv = COS_T[idx];
        sv = COS_T[(idx + 6) % 8];
        if (!c[1]) v = (c[2] ? q : i) * cv;
        else if (c[3]) v = i * sv + q * cv;
        else v = i * cv - q * sv;
        v = v >>> 14;
        if (v > 8191) v = 8191;
        if (v < -8192) v = -8192;
        return v[SAMPLE_W-1:0];
    endfunction : expDac

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] data);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        data = hrdata;
    endtask : xfer

    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycCnt++;
        if (cycCnt == 30000) begin
            errorCnt++;
            summarize();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {reset_n, hsel, hwrite, run, slow} = '0;
        {haddr, hwdata, htrans, valI, valQ} = '0;
        lfsr = 16'h004F;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        xfer(REG_CTRL, 1'b0, 32'h0000_0000, rd);
        check("ctrl reset", rd, {24'h00_0000, CTRL_RESET});
        xfer(12'h00C, 1'b1, 32'hFFFF_FFFF, rd);
        xfer(12'h00C, 1'b0, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        xfer(REG_CTRL, 1'b1, 32'hFFFF_FFF6, rd);
        xfer(REG_CTRL, 1'b0, 32'h0000_0000, rd);
        check("ctrl readback", rd, 32'h0000_00F6);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
        $display("test registers done");
        for (int u = 0; u < 4; u++) begin
            run <= 1'b1;
            xfer(REG_CTRL, 1'b1, 32'h0000_0000, rd);
            repeat (24) @(posedge ref_clk);
            xfer(REG_STATUS, 1'b0, 32'h0000_0000, rd);
            check("status full", rd, 32'h0000_1004);
            check("ready when full", {31'h0, sampleReady}, 32'h0000_0000);
            run <= 1'b0;
            xfer(REG_CTRL, 1'b1, {24'h00_0000, u[1:0], 6'h01}, rd);
            repeat (32) @(posedge ref_clk);
            xfer(REG_STATUS, 1'b0, 32'h0000_0000, rd);
            lvl = (16 - (32 >> u) < 0) ? 0 : 16 - (32 >> u);
            check("pace level", {27'h0, rd[12:8]}, lvl);
            check("underrun", {31'h0, rd[0]}, {31'h0, u == 0});
            xfer(REG_CTRL, 1'b1, 32'h0000_0000, rd);
            xfer(REG_STATUS, 1'b1, 32'h0000_0001, rd);
            xfer(REG_STATUS, 1'b0, 32'h0000_0000, rd);
            check("underrun clear", {31'h0, rd[0]}, 32'h0000_0000);
        end
        $display("test fifo and pacing done");
        run <= 1'b1;
        // every mode, random then extreme data
        for (int rep = 0; rep < 2; rep++) begin
            for (int m = 0; m < 16; m++) begin
                lfsr = lfsrNext(lfsr);
                valI <= rep ? 14'h1FFF : lfsr[13:0];
                lfsr = lfsrNext(lfsr);
                valQ <= rep ? (m[1] ? 14'h1FFF : 14'h2000) : lfsr[13:0];
                slow <= lfsr[15];
                ctrl = {lfsr[14:13], m[3:2], m[0] ? m[1] : lfsr[3],
                        m[0] ? lfsr[3] : m[1], m[0], 1'b1};
                xfer(REG_CTRL, 1'b1, {24'h00_0000, ctrl}, rd);
                repeat (180) @(posedge ref_clk);
                for (int t = 0; t < 16; t++) begin
                    @(negedge ref_clk);
                    seen[t] = dacData;
                end
                per = 1 << ctrl[5:4];
                found = 1'b0;
                for (int k = 0; k < per; k++) begin
                    ok = 1'b1;
                    for (int t = 0; t < 16; t++) begin
                        if (seen[t] !== expDac($signed(valI), $signed(valQ), ctrl,
                                               ((k + t) % per) * (8 / per))) ok = 1'b0;
                    end
                    found = found | ok;
                end
                check("dacData mix", {31'h0, found}, 32'h0000_0001);
            end
        end
        $display("test modulation done");
        summarize();
    end
endmodule : dcm_dac_channel_modulator_test
